// [hdl/fsp_pkg.sv]
`default_nettype none
package fsp_pkg;
  // Address arithmetic in program addresses, two per instruction word; the boot size limit counts pages
  localparam int ADDR_W = 24;
  localparam int LIMIT_W = 13;
  // One page is 512 instruction words, two addresses per word
  localparam int PAGE_WORDS = 512;
  localparam int PAGE_ADDR_SHIFT = 10;
  localparam int HALF_PAGE_WORDS = 256;
  localparam logic [ADDR_W-1:0] CFG_ADDR_SMALL = 24'h002BFE;
  localparam logic [ADDR_W-1:0] CFG_ADDR_LARGE = 24'h0057FE;
  // Vector table occupies addresses below this bound
  localparam logic [ADDR_W-1:0] VEC_END_ADDR = 24'h000200;
  // Security word field positions
  localparam int SEC_BWRP_POS = 0;
  localparam int SEC_BSS_POS = 1;
  localparam int SEC_BSEN_POS = 3;
  localparam int SEC_GWRP_POS = 4;
  localparam int SEC_GSS_POS = 5;
  localparam int SEC_CWRP_POS = 7;
  localparam int SEC_CSS_POS = 8;
  localparam int SEC_ALT_EN_POS = 15;
  localparam int SEC_W = 16;
  localparam logic [SEC_W-1:0] SEC_RESET = 16'hFFFF;
  localparam logic [LIMIT_W-1:0] LIMIT_RESET = 13'h1FFF;
  typedef enum logic [1:0] {FSP_REG_BOOT, FSP_REG_GEN, FSP_REG_CFG, FSP_REG_NONE} fsp_region_e;
  typedef enum logic {FSP_OP_PROG, FSP_OP_ERASE} fsp_op_e;
endpackage
`default_nettype wire

// [hdl/fsp_region_map.sv]
`default_nettype none
module fsp_region_map #(
  parameter int ADDR_W = fsp_pkg::ADDR_W
) (
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [ADDR_W-1:0] boot_end,
  input wire logic [ADDR_W-1:0] cfg_base,
  input wire logic boot_en,
  output logic [1:0] region,
  output logic in_vec
);
  wire logic in_boot = boot_en && (addr < boot_end);
  wire logic in_cfg = addr >= cfg_base;
  wire logic in_gen = !in_boot && !in_cfg;
  assign in_vec = addr < fsp_pkg::VEC_END_ADDR;
  assign region = in_boot ? 2'(fsp_pkg::FSP_REG_BOOT) :
                  in_gen ? 2'(fsp_pkg::FSP_REG_GEN) : 2'(fsp_pkg::FSP_REG_CFG);
endmodule
`default_nettype wire

// [hdl/fsp_protect.sv]
`default_nettype none
module fsp_protect #(
  parameter bit LARGE_FLASH = 1'b1,
  parameter int ADDR_W = fsp_pkg::ADDR_W,
  parameter int LIMIT_W = fsp_pkg::LIMIT_W
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cfg_load,
  input wire logic [fsp_pkg::SEC_W-1:0] security_config_word,
  input wire logic [LIMIT_W-1:0] boot_size_limit,
  input wire logic req_valid,
  input wire logic req_erase,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [ADDR_W-1:0] caller_addr,
  output logic grant,
  output logic deny,
  output logic [ADDR_W-1:0] boot_end_addr,
  output logic [ADDR_W-1:0] general_end_addr,
  output logic boot_enabled,
  output logic alt_table_enabled,
  output logic [1:0] req_region
);

  // Latched protection fields
  logic boot_wp_ff;
  logic gen_wp_ff;
  logic cfg_wp_ff;
  logic boot_on_ff;
  logic alt_on_ff;
  logic [LIMIT_W-1:0] lim_ff;

  // Answer and status registers
  logic grant_ff;
  logic deny_ff;
  logic [1:0] reg_ff;
  logic [ADDR_W-1:0] bend_ff;
  logic [ADDR_W-1:0] gend_ff;
  logic ben_ff;
  logic aiv_ff;

  // Next values
  logic nxt_boot_wp;
  logic nxt_gen_wp;
  logic nxt_cfg_wp;
  logic nxt_boot_on;
  logic nxt_alt_on;
  logic [LIMIT_W-1:0] nxt_lim;
  logic nxt_grant;
  logic nxt_deny;
  logic [1:0] nxt_reg;
  logic [ADDR_W-1:0] nxt_bend;
  logic [ADDR_W-1:0] nxt_gend;
  logic nxt_ben;
  logic nxt_aiv;

  // Boundaries and lookups
  logic [ADDR_W-1:0] cfg_base;
  logic [ADDR_W-1:0] page_span;
  logic [ADDR_W-1:0] half_span;
  logic [ADDR_W-1:0] last_page_base;
  logic [LIMIT_W-1:0] min_pages;
  logic lim_ok;
  logic lim_set;
  logic boot_en;
  logic alt_en;
  logic [ADDR_W-1:0] boot_end;
  logic [ADDR_W-1:0] lastb_base;
  logic [ADDR_W-1:0] lastb_half;
  logic [1:0] t_region;
  logic t_vec;
  logic [1:0] c_region;

  // Request decision terms
  logic from_boot;
  logic from_gen;
  logic t_boot;
  logic t_gen;
  logic t_cfg;
  logic t_lastb;
  logic t_unusable;
  logic t_alt;
  logic t_lastpage;
  logic lastb_free;
  logic boot_block;
  logic gen_block;
  logic cfg_block;
  logic last_erase_block;
  logic vec_block;
  logic vec_gen;
  logic priv_block;
  logic forbid;

  // Fields are active low, as erased flash reads ones; latched on each cfg_load so a
  // mid-operation rewrite cannot widen access
  assign nxt_boot_wp =
    cfg_load ? !security_config_word[fsp_pkg::SEC_BWRP_POS] : boot_wp_ff;
  assign nxt_gen_wp =
    cfg_load ? !security_config_word[fsp_pkg::SEC_GWRP_POS] : gen_wp_ff;
  assign nxt_cfg_wp =
    cfg_load ? !security_config_word[fsp_pkg::SEC_CWRP_POS] : cfg_wp_ff;
  assign nxt_boot_on =
    cfg_load ? !security_config_word[fsp_pkg::SEC_BSEN_POS] : boot_on_ff;
  assign nxt_alt_on =
    cfg_load ? !security_config_word[fsp_pkg::SEC_ALT_EN_POS] : alt_on_ff;
  assign nxt_lim = cfg_load ? boot_size_limit : lim_ff;

  // Config base fixed by flash size variant
  assign cfg_base = LARGE_FLASH ? ADDR_W'(fsp_pkg::CFG_ADDR_LARGE) :
    ADDR_W'(fsp_pkg::CFG_ADDR_SMALL);
  assign page_span = ADDR_W'(1) << fsp_pkg::PAGE_ADDR_SHIFT;
  assign half_span = ADDR_W'(fsp_pkg::HALF_PAGE_WORDS * 2);
  // Last flash page holds both general code and config words
  assign last_page_base = cfg_base & ~(page_span - ADDR_W'(1));

  // Boot region needs one page, or two with the alternate table
  assign min_pages = alt_on_ff ? LIMIT_W'(2) : LIMIT_W'(1);
  assign lim_ok = lim_ff >= min_pages;
  // All ones is the erased limit and means no boot region
  assign lim_set = lim_ff != {LIMIT_W{1'b1}};
  assign boot_en = boot_on_ff && lim_ok && lim_set;
  assign alt_en = boot_en && alt_on_ff;
  assign boot_end = ADDR_W'(lim_ff) << fsp_pkg::PAGE_ADDR_SHIFT;
  assign lastb_base = boot_end - page_span;
  // Second half of last boot page is unusable
  assign lastb_half = lastb_base + half_span;

  fsp_region_map #(.ADDR_W(ADDR_W)) u_target (
    .addr(req_addr),
    .boot_end(boot_end),
    .cfg_base(cfg_base),
    .boot_en(boot_en),
    .region(t_region),
    .in_vec(t_vec)
  );
  // Caller lookup needs only the region
  fsp_region_map #(.ADDR_W(ADDR_W)) u_caller (
    .addr(caller_addr),
    .boot_end(boot_end),
    .cfg_base(cfg_base),
    .boot_en(boot_en),
    .region(c_region),
    .in_vec()
  );

  assign from_boot = c_region == 2'(fsp_pkg::FSP_REG_BOOT);
  assign from_gen = c_region == 2'(fsp_pkg::FSP_REG_GEN);
  assign t_boot = t_region == 2'(fsp_pkg::FSP_REG_BOOT);
  assign t_gen = t_region == 2'(fsp_pkg::FSP_REG_GEN);
  assign t_cfg = t_region == 2'(fsp_pkg::FSP_REG_CFG);
  assign t_lastb = t_boot && (req_addr >= lastb_base);
  assign t_unusable = t_lastb && (req_addr >= lastb_half);
  assign t_alt = alt_en && t_lastb;
  assign t_lastpage = req_addr >= last_page_base;
  // Boot code may still refresh its last page
  assign lastb_free = t_lastb && from_boot;
  assign boot_block = boot_wp_ff && t_boot && !t_alt && !lastb_free;
  assign gen_block = gen_wp_ff && t_gen;
  assign cfg_block = cfg_wp_ff && t_cfg;
  // Erase only: programming the shared page stays open
  assign last_erase_block = req_erase && t_lastpage && cfg_wp_ff;
  assign vec_block = t_vec && (boot_wp_ff || gen_wp_ff);
  // Without boot region the table already falls in general security
  assign vec_gen = t_vec && !boot_en && gen_wp_ff;
  // General code may not write boot code; the alternate table page stays open
  assign priv_block = t_boot && from_gen && !t_alt;
  assign forbid = boot_block || gen_block || cfg_block ||
    last_erase_block || vec_block || vec_gen ||
    priv_block || t_unusable;

  assign nxt_grant = req_valid && !forbid;
  assign nxt_deny = req_valid && forbid;
  // Region of the last request stands until the next one
  assign nxt_reg = req_valid ? t_region : reg_ff;
  assign nxt_bend = boot_en ? boot_end : {ADDR_W{1'b0}};
  assign nxt_gend = cfg_base;
  assign nxt_ben = boot_en;
  assign nxt_aiv = alt_en;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      boot_wp_ff <= !fsp_pkg::SEC_RESET[fsp_pkg::SEC_BWRP_POS];
    end else begin
      boot_wp_ff <= nxt_boot_wp;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gen_wp_ff <= !fsp_pkg::SEC_RESET[fsp_pkg::SEC_GWRP_POS];
    end else begin
      gen_wp_ff <= nxt_gen_wp;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_wp_ff <= !fsp_pkg::SEC_RESET[fsp_pkg::SEC_CWRP_POS];
    end else begin
      cfg_wp_ff <= nxt_cfg_wp;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      boot_on_ff <= !fsp_pkg::SEC_RESET[fsp_pkg::SEC_BSEN_POS];
    end else begin
      boot_on_ff <= nxt_boot_on;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      alt_on_ff <= !fsp_pkg::SEC_RESET[fsp_pkg::SEC_ALT_EN_POS];
    end else begin
      alt_on_ff <= nxt_alt_on;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lim_ff <= LIMIT_W'(fsp_pkg::LIMIT_RESET);
    end else begin
      lim_ff <= nxt_lim;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      grant_ff <= 1'b0;
    end else begin
      grant_ff <= nxt_grant;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      deny_ff <= 1'b0;
    end else begin
      deny_ff <= nxt_deny;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_ff <= 2'(fsp_pkg::FSP_REG_NONE);
    end else begin
      reg_ff <= nxt_reg;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bend_ff <= {ADDR_W{1'b0}};
    end else begin
      bend_ff <= nxt_bend;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gend_ff <= {ADDR_W{1'b0}};
    end else begin
      gend_ff <= nxt_gend;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ben_ff <= 1'b0;
    end else begin
      ben_ff <= nxt_ben;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aiv_ff <= 1'b0;
    end else begin
      aiv_ff <= nxt_aiv;
    end
  end

  assign grant = grant_ff;
  assign deny = deny_ff;
  assign boot_end_addr = bend_ff;
  assign general_end_addr = gend_ff;
  assign boot_enabled = ben_ff;
  assign alt_table_enabled = aiv_ff;
  assign req_region = reg_ff;
endmodule
`default_nettype wire

// [testbench/fsp_protect_asserts.sv]
`default_nettype none
module fsp_protect_asserts #(
  parameter bit LARGE_FLASH = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cfg_load,
  input wire logic req_valid,
  input wire logic grant,
  input wire logic deny,
  input wire logic [23:0] boot_end_addr,
  input wire logic [23:0] general_end_addr,
  input wire logic boot_enabled,
  input wire logic [1:0] req_region
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence req_s;
    req_valid;
  endsequence
  sequence ans_s;
    ##1 (grant ^ deny);
  endsequence
  one_answer_a: assert property (req_s |-> ans_s) else $error("no single answer");
  no_stray_a: assert property (!req_valid |=> !grant && !deny) else $error("stray answer");
  excl_answer_a: assert property (!(grant && deny)) else $error("grant with deny");
  boot_size_a: assert property (boot_enabled |-> boot_end_addr[9:0] == 10'h000
    && boot_end_addr != 24'h000000) else $error("boot end off page");
  boot_off_a: assert property (!boot_enabled |-> boot_end_addr == 24'h000000)
    else $error("boot end without boot");
  cfg_base_a: assert property ($past(resetn) |-> general_end_addr ==
    (LARGE_FLASH ? fsp_pkg::CFG_ADDR_LARGE : fsp_pkg::CFG_ADDR_SMALL)) else $error("cfg base");
  // Boot end and boot enable may only move after a config capture
  status_hold_a: assert property (!cfg_load && !$past(cfg_load) && $past(resetn)
    |=> $stable(boot_end_addr) && $stable(boot_enabled)) else $error("status moved");
  region_hold_a: assert property (!req_valid && $past(resetn) |=> $stable(req_region))
    else $error("region moved");
endmodule
bind fsp_protect fsp_protect_asserts #(.LARGE_FLASH(LARGE_FLASH)) fsp_protect_asserts_i (
  .clock(clock), .resetn(resetn), .cfg_load(cfg_load), .req_valid(req_valid),
  .grant(grant), .deny(deny), .boot_end_addr(boot_end_addr),
  .general_end_addr(general_end_addr), .boot_enabled(boot_enabled), .req_region(req_region));
`default_nettype wire

// [testbench/fsp_requester.sv]
`default_nettype none
module fsp_requester (
  input wire logic clock,
  input wire logic grant,
  input wire logic deny,
  output logic req_valid = 1'b0,
  output logic req_erase = 1'b0,
  output logic [23:0] req_addr = 24'h000000,
  output logic [23:0] caller_addr = 24'h000000
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic issue(input logic [23:0] a, input logic e, input logic [23:0] c,
    output logic g, output logic d);
    @(posedge clock);
    req_valid <= 1'b1;
    req_erase <= e;
    req_addr <= a;
    caller_addr <= c;
    @(posedge clock);
    req_valid <= 1'b0;
    // Garbage after release, so a stale address is never trusted
    req_addr <= ~a;
    #1;
    g = grant;
    d = deny;
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, cfg_load, rv, re, grant, deny, be, ae;
  logic [15:0] sw;
  logic [12:0] bl;
  logic [23:0] ra, ca, bea, gea;
  logic [1:0] rg;
  int num_errors = 0;
  int num_checks = 0;
  fsp_protect fsp_protect_i (.clock(clock), .resetn(resetn), .cfg_load(cfg_load),
    .security_config_word(sw), .boot_size_limit(bl), .req_valid(rv), .req_erase(re),
    .req_addr(ra), .caller_addr(ca), .grant(grant), .deny(deny), .boot_end_addr(bea),
    .general_end_addr(gea), .boot_enabled(be), .alt_table_enabled(ae), .req_region(rg));
  fsp_requester fsp_requester_i (.clock(clock), .grant(grant), .deny(deny),
    .req_valid(rv), .req_erase(re), .req_addr(ra), .caller_addr(ca));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cfg(input logic [15:0] w, input logic [12:0] l, input logic xb,
    input logic [23:0] xe);
    @(posedge clock);
    cfg_load <= 1'b1;
    sw <= w;
    bl <= l;
    @(posedge clock);
    cfg_load <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("boot_enabled", xb, be);
    chk("boot_end_addr", xe, bea);
  endtask
  task automatic rq(input logic [23:0] a, input logic e, input logic [23:0] c, input logic x);
    logic g, d;
    fsp_requester_i.issue(a, e, c, g, d);
    chk("grant", x, g);
    chk("deny", !x, d);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    num_errors++;
    final_report();
  end
  initial begin
    resetn = 1'b0;
    cfg_load = 1'b0;
    sw = 16'hFFFF;
    bl = 13'h1FFF;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    chk("general_end_addr", fsp_pkg::CFG_ADDR_LARGE, gea);
    chk("req_region", 24'h000003, rg);
    rq(24'h000100, 1'b0, 24'h002000, 1'b1);
    rq(24'h002000, 1'b0, 24'h002000, 1'b1);
    chk("req_region", 24'h000001, rg);
    rq(24'h0057FE, 1'b0, 24'h002000, 1'b1);
    chk("req_region", 24'h000002, rg);
    $display("test open done");
    cfg(16'hFFF6, 13'h0004, 1'b1, 24'h001000);
    rq(24'h000400, 1'b0, 24'h002000, 1'b0);
    rq(24'h000100, 1'b1, 24'h002000, 1'b0);
    rq(24'h000C00, 1'b0, 24'h000500, 1'b1);
    rq(24'h000E00, 1'b0, 24'h000500, 1'b0);
    rq(24'h002000, 1'b0, 24'h002000, 1'b1);
    $display("test boot done");
    cfg(16'hFFF7, 13'h0001, 1'b1, 24'h000400);
    cfg(16'h7FF7, 13'h0001, 1'b0, 24'h000000);
    cfg(16'h7FF7, 13'h0002, 1'b1, 24'h000800);
    chk("alt_table_enabled", 24'h000001, ae);
    cfg(16'h7FF6, 13'h0002, 1'b1, 24'h000800);
    rq(24'h000400, 1'b0, 24'h002000, 1'b1);
    rq(24'h000200, 1'b0, 24'h002000, 1'b0);
    $display("test alt done");
    cfg(16'hFF7F, 13'h1FFF, 1'b0, 24'h000000);
    rq(24'h005400, 1'b1, 24'h002000, 1'b0);
    rq(24'h005400, 1'b0, 24'h002000, 1'b1);
    rq(24'h000100, 1'b0, 24'h002000, 1'b1);
    cfg(16'hFFEF, 13'h1FFF, 1'b0, 24'h000000);
    rq(24'h000100, 1'b0, 24'h002000, 1'b0);
    $display("test general done");
    final_report();
  end
endmodule
`default_nettype wire
